// >>> design/dcr_pkg.sv
// package of register offsets, bit positions and reset values for the diagnostic registers
// assumes one 40 MHz clock and a plain register port with byte-wide data
package dcr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] SELF_CHECK_ENABLES_ADDR   = 8'h21;
  localparam logic [7:0] SELF_CHECK_FAULTS_ADDR    = 8'h22;
  localparam logic [7:0] BREAK_CHECK_ENABLES_ADDR  = 8'h23;
  localparam logic [7:0] BREAK_FLAGS_ADDR          = 8'h24;
  localparam logic [7:0] LIMIT_CHECK_ENABLES_ADDR  = 8'h25;
  localparam logic [7:0] OVER_LIMIT_FLAGS_ADDR     = 8'h26;
  localparam logic [7:0] UNDER_LIMIT_FLAGS_ADDR    = 8'h27;
  localparam logic [7:0] IRQ_STATUS_ADDR           = 8'h30;
  localparam logic [7:0] IRQ_ENABLE_ADDR           = 8'h31;
  localparam logic [7:0] IRQ_CLEAR_ADDR            = 8'h32;
  localparam logic [7:0] MODE_CTRL_ADDR            = 8'h33;
  // ****************************************
  // bit positions in enables and faults
  // ****************************************
  localparam int PATTERN_BIT  = 7;
  localparam int TALLY_BIT    = 6;
  localparam int BUSY_BIT     = 5;
  localparam int RD_ADDR_BIT  = 4;
  localparam int WR_ADDR_BIT  = 3;
  localparam int IF_CRC_BIT   = 2;
  localparam int MAP_CRC_BIT  = 1;
  localparam int ROM_CRC_BIT  = 0;
  // irq status bits: one per fault group
  localparam int IRQ_SELF_BIT  = 0;
  localparam int IRQ_BREAK_BIT = 1;
  localparam int IRQ_OVER_BIT  = 2;
  localparam int IRQ_UNDER_BIT = 3;
  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [7:0] SELF_CHECK_ENABLES_RST = 8'h01;
  localparam logic [7:0] FLAGS_RST              = 8'h00;
  localparam logic [7:0] FAULT_WRITABLE_MASK    = 8'h3f;
  localparam logic [3:0] IRQ_RST                = 4'h0;
  localparam logic [15:0] PATTERN_WORD          = 16'haaaa;
  // ****************************************
  // busy watchdog timing
  // ****************************************
  localparam int CLK_HZ         = 40_000_000;
  localparam int BUSY_LIMIT_NS  = 4000;
  localparam int BUSY_LIMIT_CYC = (BUSY_LIMIT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int BUSY_CNT_W     = 8;
  localparam int TALLY_W        = 16;
endpackage : dcr_pkg

// >>> design/dcr_busy_watch.sv
// busy-stuck-high watchdog counting cycles of continuous busy
// assumes busy is synchronous to clk
`timescale 1ns/1ps
module dcr_busy_watch (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // supervision
  input  wire logic armed,
  input  wire logic busy,
  output logic      stuck
);
  typedef struct packed {
    logic [dcr_pkg::BUSY_CNT_W-1:0] count;
    logic                           stuck;
  } dcr_watch_type;
  dcr_watch_type state;
  dcr_watch_type next_state;

  // count run of busy; pulse once past the limit
  always_comb begin
    next_state = state;
    next_state.stuck = 1'b0;
    if (!armed || !busy) begin
      next_state.count = '0;
    end else if (state.count < dcr_pkg::BUSY_CNT_W'(dcr_pkg::BUSY_LIMIT_CYC + 1)) begin
      next_state.count = state.count + 1'b1;
      // more than limit cycles high
      next_state.stuck = (state.count == dcr_pkg::BUSY_CNT_W'(dcr_pkg::BUSY_LIMIT_CYC));
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign stuck = state.stuck;

  chk_stuck_needs_arm: assert property (@(posedge clk) disable iff (!rst_n)
    stuck |-> $past(armed) && $past(busy))
    else $error("busy stuck pulse without armed busy");
endmodule : dcr_busy_watch

// >>> design/dcr_regs.sv
// diagnostic check register bank with sticky fault flags and an interrupt
// assumes a synchronous host register port, one clock, busy and fault
// detectors that are synchronous to clk
// Notes on behaviour
// - pattern bit replaces conversion data with fixed word
// - tally bit runs the sample clock counter
// - busy bit arms stuck-high supervision
// - busy high over 4 us sets fault
// - read of unmapped address sets read fault
// - write to unmapped address sets write fault
// - interface crc mismatch sets fault when enabled
// - map crc check, off after reset
// - rom crc check, on after reset
// - faults sticky, write one clears, 7:6 reserved
// - auto mode: break bit enables open detect
// - manual mode: break bit forces amp common mode high
// - open input sets sticky break flag
// - limit enable bit arms channel voltage check
// - overvoltage sets sticky over flag
// - undervoltage sets separate sticky under flag
`timescale 1ns/1ps
module dcr_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // fault events from the converter
  input  wire logic        busy,
  input  wire logic        ifCrcMismatch,
  input  wire logic        mapCrcMismatch,
  input  wire logic        romCrcMismatch,
  input  wire logic [7:0]  inputBreakSeen,
  input  wire logic [7:0]  inputOverLimit,
  input  wire logic [7:0]  inputUnderLimit,
  // conversion data path and clocks
  input  wire logic [15:0] convData,
  input  wire logic        sampleRateClock,
  input  wire logic        oversamplingClock,
  output logic      [15:0] readData,
  // controls to the analog side
  output logic      [7:0]  inputBreakCheckOn,
  output logic      [7:0]  ampCommonHigh,
  output logic      [7:0]  inputLimitCheckOn,
  output logic      [15:0] sampleRateClockTally,
  // interrupt
  output logic             irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]                  enables;
    logic [7:0]                  faults;
    logic [7:0]                  breakOn;
    logic [7:0]                  breakFlags;
    logic [7:0]                  limitOn;
    logic [7:0]                  overFlags;
    logic [7:0]                  underFlags;
    logic [3:0]                  irqStatus;
    logic [3:0]                  irqEnable;
    logic                        manualMode;
    logic [7:0]                  rdata;
    logic [15:0]                 readData;
    logic [7:0]                  commonHigh;
    logic [7:0]                  breakCheck;
    logic [dcr_pkg::TALLY_W-1:0] tally;
    logic                        irq;
  } dcr_regs_type;
  dcr_regs_type state;
  dcr_regs_type next_state;

  logic busyStuck;

  // ****************************************
  // busy watchdog
  // ****************************************
  dcr_busy_watch u_busy_watch (
    .clk   (clk),
    .rst_n (rst_n),
    .armed (state.enables[dcr_pkg::BUSY_BIT]),
    .busy  (busy),
    .stuck (busyStuck)
  );

  // address decode used for reads and writes
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a >= dcr_pkg::SELF_CHECK_ENABLES_ADDR && a <= dcr_pkg::UNDER_LIMIT_FLAGS_ADDR)
        || (a >= dcr_pkg::IRQ_STATUS_ADDR && a <= dcr_pkg::MODE_CTRL_ADDR);
  endfunction : addr_mapped

  // sticky flag: set wins over clear; write one clears
  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] setv,
                                        input logic clr, input logic [7:0] wd);
    return (cur & ~(clr ? wd : 8'h00)) | setv;
  endfunction : sticky

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] selfSet;
    logic [3:0] irqSet;
    selfSet = 8'h00;
    irqSet = 4'h0;
    next_state = state;
    // fault events gated by their enables
    selfSet[dcr_pkg::BUSY_BIT]    = busyStuck;
    selfSet[dcr_pkg::RD_ADDR_BIT] = state.enables[dcr_pkg::RD_ADDR_BIT] && regRead
                                    && !addr_mapped(regAddr);
    selfSet[dcr_pkg::WR_ADDR_BIT] = state.enables[dcr_pkg::WR_ADDR_BIT] && regWrite
                                    && !addr_mapped(regAddr);
    selfSet[dcr_pkg::IF_CRC_BIT]  = state.enables[dcr_pkg::IF_CRC_BIT] && ifCrcMismatch;
    selfSet[dcr_pkg::MAP_CRC_BIT] = state.enables[dcr_pkg::MAP_CRC_BIT] && mapCrcMismatch;
    selfSet[dcr_pkg::ROM_CRC_BIT] = state.enables[dcr_pkg::ROM_CRC_BIT] && romCrcMismatch;
    // register writes
    if (regWrite) begin
      unique case (regAddr)
        dcr_pkg::SELF_CHECK_ENABLES_ADDR:  next_state.enables = regWdata;
        dcr_pkg::BREAK_CHECK_ENABLES_ADDR: next_state.breakOn = regWdata;
        dcr_pkg::LIMIT_CHECK_ENABLES_ADDR: next_state.limitOn = regWdata;
        dcr_pkg::IRQ_ENABLE_ADDR:          next_state.irqEnable = regWdata[3:0];
        dcr_pkg::MODE_CTRL_ADDR:           next_state.manualMode = regWdata[0];
        default:                           ;
      endcase
    end
    // sticky fault flags, reserved bits stay zero
    next_state.faults = sticky(state.faults, selfSet,
      regWrite && regAddr == dcr_pkg::SELF_CHECK_FAULTS_ADDR, regWdata)
      & dcr_pkg::FAULT_WRITABLE_MASK;
    next_state.breakFlags = sticky(state.breakFlags,
      inputBreakSeen & state.breakOn & {8{!state.manualMode}},
      regWrite && regAddr == dcr_pkg::BREAK_FLAGS_ADDR, regWdata);
    next_state.overFlags = sticky(state.overFlags, inputOverLimit & state.limitOn,
      regWrite && regAddr == dcr_pkg::OVER_LIMIT_FLAGS_ADDR, regWdata);
    next_state.underFlags = sticky(state.underFlags, inputUnderLimit & state.limitOn,
      regWrite && regAddr == dcr_pkg::UNDER_LIMIT_FLAGS_ADDR, regWdata);
    // interrupt status follows new flag events
    irqSet[dcr_pkg::IRQ_SELF_BIT]  = |(next_state.faults & ~state.faults);
    irqSet[dcr_pkg::IRQ_BREAK_BIT] = |(next_state.breakFlags & ~state.breakFlags);
    irqSet[dcr_pkg::IRQ_OVER_BIT]  = |(next_state.overFlags & ~state.overFlags);
    irqSet[dcr_pkg::IRQ_UNDER_BIT] = |(next_state.underFlags & ~state.underFlags);
    next_state.irqStatus = (state.irqStatus
      & ~((regWrite && regAddr == dcr_pkg::IRQ_CLEAR_ADDR) ? regWdata[3:0] : 4'h0)) | irqSet;
    next_state.irq = |(next_state.irqStatus & next_state.irqEnable);
    // read data, one cycle later
    next_state.rdata = 8'h00;
    if (regRead) begin
      unique case (regAddr)
        dcr_pkg::SELF_CHECK_ENABLES_ADDR:  next_state.rdata = state.enables;
        dcr_pkg::SELF_CHECK_FAULTS_ADDR:   next_state.rdata = state.faults;
        dcr_pkg::BREAK_CHECK_ENABLES_ADDR: next_state.rdata = state.breakOn;
        dcr_pkg::BREAK_FLAGS_ADDR:         next_state.rdata = state.breakFlags;
        dcr_pkg::LIMIT_CHECK_ENABLES_ADDR: next_state.rdata = state.limitOn;
        dcr_pkg::OVER_LIMIT_FLAGS_ADDR:    next_state.rdata = state.overFlags;
        dcr_pkg::UNDER_LIMIT_FLAGS_ADDR:   next_state.rdata = state.underFlags;
        dcr_pkg::IRQ_STATUS_ADDR:          next_state.rdata = {4'h0, state.irqStatus};
        dcr_pkg::IRQ_ENABLE_ADDR:          next_state.rdata = {4'h0, state.irqEnable};
        dcr_pkg::MODE_CTRL_ADDR:           next_state.rdata = {7'h00, state.manualMode};
        default:                           next_state.rdata = 8'h00;
      endcase
    end
    // conversion data or fixed check pattern
    next_state.readData = state.enables[dcr_pkg::PATTERN_BIT]
                          ? dcr_pkg::PATTERN_WORD : convData;
    // manual mode uses break bits as common mode control
    next_state.commonHigh = state.manualMode ? state.breakOn : 8'h00;
    // break enables reach the detectors only in automatic mode
    next_state.breakCheck = next_state.manualMode ? 8'h00 : next_state.breakOn;
    // tally of sample and oversampling clock ticks
    if (state.enables[dcr_pkg::TALLY_BIT]) begin
      next_state.tally = state.tally + TALLY_CNT(sampleRateClock, oversamplingClock);
    end
  end

  // count of clock ticks this cycle
  function automatic logic [dcr_pkg::TALLY_W-1:0] TALLY_CNT(input logic a, input logic b);
    return dcr_pkg::TALLY_W'({1'b0, a} + {1'b0, b});
  endfunction : TALLY_CNT

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.enables <= dcr_pkg::SELF_CHECK_ENABLES_RST;
      state.breakOn <= dcr_pkg::FLAGS_RST;
      state.limitOn <= dcr_pkg::FLAGS_RST;
      state.irqStatus <= dcr_pkg::IRQ_RST;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign regRdata             = state.rdata;
  assign readData             = state.readData;
  assign inputBreakCheckOn    = state.breakCheck;
  assign ampCommonHigh        = state.commonHigh;
  assign inputLimitCheckOn    = state.limitOn;
  assign sampleRateClockTally = state.tally;
  assign irq                  = state.irq;

  // ****************************************
  // checks
  // ****************************************
  chk_pattern_output: assert property (@(posedge clk) disable iff (!rst_n)
    state.enables[dcr_pkg::PATTERN_BIT] |=> readData == dcr_pkg::PATTERN_WORD)
    else $error("pattern not returned");
  chk_tally_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !state.enables[dcr_pkg::TALLY_BIT] |=> $stable(sampleRateClockTally))
    else $error("tally moved while off");
  chk_busy_disarmed: assert property (@(posedge clk) disable iff (!rst_n)
    !state.enables[dcr_pkg::BUSY_BIT] [*2] |=> !$rose(state.faults[dcr_pkg::BUSY_BIT]))
    else $error("busy fault while disarmed");
  // ****************************************
  // assertion helper: run of armed busy cycles
  // ****************************************
  // saturating count of consecutive cycles with busy high while armed
  logic [8:0] busyRun;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyRun <= 9'h000;
    end else if (!(state.enables[dcr_pkg::BUSY_BIT] && busy)) begin
      busyRun <= 9'h000;
    end else if (busyRun != 9'h1ff) begin
      busyRun <= busyRun + 9'h001;
    end
  end

  // one cycle past the limit the watchdog pulses, the flag follows
  chk_busy_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    busyRun == 9'(dcr_pkg::BUSY_LIMIT_CYC + 1) |=> state.faults[dcr_pkg::BUSY_BIT])
    else $error("busy fault late");
  chk_read_fault: assert property (@(posedge clk) disable iff (!rst_n)
    regRead && !addr_mapped(regAddr) && state.enables[dcr_pkg::RD_ADDR_BIT]
    |=> state.faults[dcr_pkg::RD_ADDR_BIT])
    else $error("read fault missing");
  chk_write_fault: assert property (@(posedge clk) disable iff (!rst_n)
    regWrite && !addr_mapped(regAddr) && state.enables[dcr_pkg::WR_ADDR_BIT]
    |=> state.faults[dcr_pkg::WR_ADDR_BIT])
    else $error("write fault missing");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    state.faults[7:6] == 2'b00)
    else $error("reserved fault bits set");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    state.overFlags[0] && !(regWrite && regAddr == dcr_pkg::OVER_LIMIT_FLAGS_ADDR)
    |=> state.overFlags[0])
    else $error("over flag lost");
  chk_under_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !state.limitOn[0] && !state.underFlags[0] |=> !state.underFlags[0])
    else $error("under flag set while off");
  chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |($past(next_state.irqStatus) & $past(next_state.irqEnable)))
    else $error("irq mismatch");
  // conversion data passes through while the pattern is off
  chk_conv_passes: assert property (@(posedge clk) disable iff (!rst_n)
    !state.enables[dcr_pkg::PATTERN_BIT] |=> readData == $past(convData))
    else $error("conversion data not passed");
  // one sample tick alone adds exactly one
  chk_tally_step: assert property (@(posedge clk) disable iff (!rst_n)
    state.enables[dcr_pkg::TALLY_BIT] && sampleRateClock && !oversamplingClock
    |=> sampleRateClockTally == $past(sampleRateClockTally) + 16'h0001)
    else $error("tally step wrong");
  // crc mismatches latch when their checks are on
  chk_if_crc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    state.enables[dcr_pkg::IF_CRC_BIT] && ifCrcMismatch |=> state.faults[dcr_pkg::IF_CRC_BIT])
    else $error("interface crc fault missing");
  chk_map_crc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    state.enables[dcr_pkg::MAP_CRC_BIT] && mapCrcMismatch
    |=> state.faults[dcr_pkg::MAP_CRC_BIT])
    else $error("map crc fault missing");
  chk_rom_crc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    state.enables[dcr_pkg::ROM_CRC_BIT] && romCrcMismatch
    |=> state.faults[dcr_pkg::ROM_CRC_BIT])
    else $error("rom crc fault missing");
  // break enables go out only in automatic mode
  chk_break_auto: assert property (@(posedge clk) disable iff (!rst_n)
    !state.manualMode |-> inputBreakCheckOn == state.breakOn)
    else $error("break enables not driven");
  // manual mode: no new break flags
  chk_break_manual: assert property (@(posedge clk) disable iff (!rst_n)
    state.manualMode && !state.breakFlags[0] |=> !state.breakFlags[0])
    else $error("break flag set in manual mode");
  // manual mode hands the break bits to the amplifier common mode
  chk_common_manual: assert property (@(posedge clk) disable iff (!rst_n)
    state.manualMode |=> ampCommonHigh == $past(state.breakOn))
    else $error("common mode not forced");
  // per-channel events latch while enabled
  chk_break_set: assert property (@(posedge clk) disable iff (!rst_n)
    inputBreakSeen[7] && state.breakOn[7] && !state.manualMode |=> state.breakFlags[7])
    else $error("break flag missing");
  chk_over_set: assert property (@(posedge clk) disable iff (!rst_n)
    inputOverLimit[2] && state.limitOn[2] |=> state.overFlags[2])
    else $error("over flag missing");
  chk_under_set: assert property (@(posedge clk) disable iff (!rst_n)
    inputUnderLimit[3] && state.limitOn[3] |=> state.underFlags[3])
    else $error("under flag missing");
  // a zero written to a set flag leaves it set
  chk_zero_write: assert property (@(posedge clk) disable iff (!rst_n)
    state.faults[dcr_pkg::ROM_CRC_BIT] && regWrite && !regWdata[dcr_pkg::ROM_CRC_BIT]
    |=> state.faults[dcr_pkg::ROM_CRC_BIT])
    else $error("flag lost on zero write");
  // read data stands only in the cycle after a read
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !regRead |=> regRdata == 8'h00)
    else $error("read data without read");
  cov_busy_fault: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(state.faults[dcr_pkg::BUSY_BIT]));
  cov_flag_clear: cover property (@(posedge clk) disable iff (!rst_n)
    state.breakFlags[0] ##1 !state.breakFlags[0]);
  cov_irq_rise: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  cov_pattern_on: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(state.enables[dcr_pkg::PATTERN_BIT]));
  cov_manual_common: cover property (@(posedge clk) disable iff (!rst_n)
    state.manualMode && ampCommonHigh != 8'h00);
endmodule : dcr_regs

// >>> dv/dcr_host_model.sv
// host controller model that drives the register port of the diagnostic bank
// assumes one clock; strobes change by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module dcr_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWrite,
  output logic            regRead,
  input  wire logic [7:0] regRdata
);
  // ****************************************
  // bus cycles
  // ****************************************
  // idle port at time zero
  initial begin
    regAddr  = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
  end
  // one-cycle write; released lines show the inverse so stale values never match
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask : writeReg
  // one-cycle read; data taken in the cycle after the strobe only
  task automatic readReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask : readReg
  // read the flags, clear the handled ones, then re-read to confirm
  task automatic clearFlags(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
    readReg(a, d);
    writeReg(a, m);
    readReg(a, d);
  endtask : clearFlags
endmodule : dcr_host_model

// >>> dv/diagnostic_check_registers_bench.sv
// self-checking bench for the diagnostic check register bank
// assumes the host model owns the register port; events and clocks come from here
`timescale 1ns/1ps
module diagnostic_check_registers_bench;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        busy     = 1'b0;
  logic [2:0]  crcBad   = 3'h0;
  logic [7:0]  events   = 8'h00;
  logic [15:0] convData = 16'h1234;
  logic        srClk    = 1'b0;
  logic        osClk    = 1'b0;
  logic [7:0]  regAddr, regWdata, regRdata, breakOn, ampHigh, limitOn, rd;
  logic        regWrite, regRead, irq;
  logic [15:0] readData, tally;
  int          miscompares = 0;
  int          checked     = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  dcr_host_model dcr_host_model_inst (
    .clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata)
  );
  dcr_regs dcr_regs_inst (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .busy(busy), .ifCrcMismatch(crcBad[2]),
    .mapCrcMismatch(crcBad[1]), .romCrcMismatch(crcBad[0]), .inputBreakSeen(events),
    .inputOverLimit(events), .inputUnderLimit({events[3:0], events[7:4]}), .convData(convData),
    .sampleRateClock(srClk), .oversamplingClock(osClk), .readData(readData),
    .inputBreakCheckOn(breakOn), .ampCommonHigh(ampHigh), .inputLimitCheckOn(limitOn),
    .sampleRateClockTally(tally), .irq(irq)
  );
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    dcr_host_model_inst.readReg(a, rd);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rdChk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dcr_host_model_inst.writeReg(a, d);
  endtask : wr
  // let registered outputs land, then sample off the edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // one-cycle pulse on crc faults and all per-channel events
  task automatic pulse(input logic [2:0] c, input logic [7:0] v);
    @(posedge clk);
    crcBad <= c;
    events <= v;
    @(posedge clk);
    crcBad <= 3'h0;
    events <= 8'h00;
    @(posedge clk);
  endtask : pulse
  task automatic busyFor(input int n);
    @(posedge clk);
    busy <= 1'b1;
    repeat (n) @(posedge clk);
    busy <= 1'b0;
    @(posedge clk);
  endtask : busyFor
  // three sample-rate ticks then two oversampling ticks
  task automatic ticks;
    @(posedge clk);
    srClk <= 1'b1;
    repeat (3) @(posedge clk);
    srClk <= 1'b0;
    osClk <= 1'b1;
    repeat (2) @(posedge clk);
    osClk <= 1'b0;
    settle;
  endtask : ticks
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // ****************************************
  // test sequence
  // ****************************************
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    $display("MISMATCH %0t run did not finish", $time);
    final_report;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(8'h21, 8'h01);
    for (int a = 8'h22; a <= 8'h27; a++) begin
      rdChk(8'(a), 8'h00);
    end
    // only the rom check is armed after reset
    pulse(3'h7, 8'hff);
    rdChk(8'h22, 8'h01);
    rdChk(8'h24, 8'h00);
    rdChk(8'h26, 8'h00);
    dcr_host_model_inst.clearFlags(8'h22, 8'hff, rd);
    check({8'h00, rd}, 16'h0000);
    // crc and address checks, rom check off
    wr(8'h21, 8'h3e);
    pulse(3'h7, 8'h00);
    rdChk(8'h40, 8'h00);
    wr(8'h41, 8'h55);
    rdChk(8'h22, 8'h1e);
    wr(8'h22, 8'h00);
    rdChk(8'h22, 8'h1e);
    wr(8'h22, 8'hc2);
    rdChk(8'h22, 8'h1c);
    wr(8'h22, 8'hff);
    // busy watchdog at and beyond the limit, then disarmed
    busyFor(dcr_pkg::BUSY_LIMIT_CYC);
    rdChk(8'h22, 8'h00);
    busyFor(dcr_pkg::BUSY_LIMIT_CYC + 4);
    rdChk(8'h22, 8'h20);
    wr(8'h22, 8'h20);
    wr(8'h21, 8'h00);
    busyFor(200);
    rdChk(8'h22, 8'h00);
    // fixed pattern replaces conversion data
    wr(8'h21, 8'h80);
    settle;
    check(readData, dcr_pkg::PATTERN_WORD);
    wr(8'h21, 8'h00);
    settle;
    check(readData, 16'h1234);
    // tick counter idle, then counting
    ticks;
    check(tally, 16'h0000);
    wr(8'h21, 8'h40);
    ticks;
    check(tally, 16'h0005);
    // per-channel enables in automatic mode
    wr(8'h23, 8'h81);
    wr(8'h25, 8'h3c);
    wr(8'h32, 8'hff);
    wr(8'h31, 8'h00);
    settle;
    check({breakOn, ampHigh}, 16'h8100);
    check({8'h00, limitOn}, 16'h003c);
    pulse(3'h0, 8'hf5);
    rdChk(8'h24, 8'h81);
    rdChk(8'h26, 8'h34);
    rdChk(8'h27, 8'h1c);
    // interrupt masked, enabled, then cleared
    check({15'h0000, irq}, 16'h0000);
    rdChk(8'h30, 8'h0e);
    wr(8'h31, 8'h04);
    settle;
    check({15'h0000, irq}, 16'h0001);
    wr(8'h32, 8'h0f);
    settle;
    check({15'h0000, irq}, 16'h0000);
    rdChk(8'h30, 8'h00);
    dcr_host_model_inst.clearFlags(8'h26, 8'h04, rd);
    check({8'h00, rd}, 16'h0030);
    // manual mode moves the enables to the amplifier common mode
    wr(8'h33, 8'h01);
    settle;
    check({breakOn, ampHigh}, 16'h0081);
    final_report;
  end
endmodule : diagnostic_check_registers_bench
